// ===== msc_pkg.sv
/*
 * Shared constants, types and register map of the multimode scaler core.
 * Assumes a single 10 MHz clock domain and a 32-bit APB register bus.
 */
package msc_pkg;

    // ********************************************************
    // sizes
    // ********************************************************
    localparam int NCH = 32;
    localparam int CW = 32;
    localparam int XW = 16;
    localparam int MAW = 24;
    localparam int AW = 12;
    localparam int NSYNC = NCH + 6;
    localparam int I_REF = NCH;
    localparam int I_TB = NCH + 1;
    localparam int I_CI = NCH + 2;

    // ********************************************************
    // register map
    // ********************************************************
    localparam logic [11:0] A_CTRL = 12'h000;
    localparam logic [11:0] A_ID = 12'h004;
    localparam logic [11:0] A_ACQ_PRE = 12'h010;
    localparam logic [11:0] A_ACQ_CNT = 12'h014;
    localparam logic [11:0] A_LNE_PRE = 12'h018;
    localparam logic [11:0] A_PV1 = 12'h020;
    localparam logic [11:0] A_PV2 = 12'h024;
    localparam logic [11:0] A_PEN = 12'h028;
    localparam logic [11:0] A_HIT = 12'h02C;
    localparam logic [11:0] A_KEY = 12'h030;
    localparam logic [11:0] A_PTR = 12'h034;
    localparam logic [11:0] A_CNT = 12'h100;
    localparam logic [11:0] A_SHD = 12'h180;
    localparam logic [11:0] A_XHI1 = 12'h210;
    localparam logic [11:0] A_XHI17 = 12'h214;
    // value is arbitrary
    localparam logic [31:0] MODULE_ID = 32'h4D53_0001;

    // control fields, status bits, key bits
    localparam int C_MD = 0;
    localparam int C_HIST = 2;
    localparam int C_CMP = 3;
    localparam int C_REF = 5;
    localparam int C_TB = 6;
    localparam int C_LNEI = 7;
    localparam logic [7:0] CTRL_RST = 8'h00;
    localparam int S_RUN = 8;
    localparam int S_DONE = 9;
    localparam int S_OVR = 10;
    localparam int S_RDY = 11;
    localparam int K_LATCH = 0;
    localparam int K_CLR = 1;
    localparam int K_BIN0 = 2;
    localparam int K_EN = 3;
    localparam int K_DIS = 4;

    // ********************************************************
    // timing
    // ********************************************************
    localparam int CLK_HZ = 10_000_000;
    localparam int SELFTEST_MS = 2000;
    localparam int SELFTEST_CYC = SELFTEST_MS * (CLK_HZ / 1000);
    localparam int STOP_NS = 100;
    localparam int STOP_RAW = STOP_NS * (CLK_HZ / 1_000_000) / 1000;
    localparam int STOP_CYC = (STOP_RAW < 1) ? 1 : STOP_RAW;

    // ********************************************************
    // types
    // ********************************************************
    typedef enum logic [1:0] {
        MD_SCALER, MD_LATCH, MD_PRESET, MD_MCS
    } msc_mode_t;
    typedef enum logic [1:0] {CMP_32, CMP_16, CMP_8} msc_cmp_t;
    typedef enum logic [1:0] {ST_IDLE, ST_RUN, ST_RD, ST_WR} msc_state_t;
    typedef struct packed {
        logic req;
        logic we;
        logic [MAW-1:0] addr;
        logic [31:0] wdata;
    } msc_mem_t;

endpackage : msc_pkg

// ===== msc_core.sv
/*
 * Multimode scaler core: counters, latch, preset, scan to memory and
 * histogram add, APB register slave, self test and front panel i/o.
 * Assumes count and front panel inputs are asynchronous to mclk, the
 * memory port answers each request with a one-cycle mem_ack, and
 * bcast_latch is a one-cycle pulse from the broadcast decoder on mclk.
 */
// How it works
// - live counters readable while counting runs
// - latch mode copies counters to shadow set
// - broadcast latch input latches all modules in latch mode
// - preset enable mask selects stopping channels
// - first enabled channel at preset stops counting
// - two writable preset values, each compared on 16 channels
// - time base pulses onto channel one
// - hit mask records terminating channels
// - scan interval from timer or strobe, prescaled
// - scan intervals written into memory buffer
// - scan words pack 16 or 8 bit counts
// - histogram adds scan onto stored values
// - 32-bit counters, channels 1/17 48-bit in scaler mode
// - 32 independent counting channels
// - count inputs synchronised before counting
// - four control inputs and four outputs
// - reference pulser routable onto channel one
// - power lit from reset, self test then ready lit
// - identification word readable
// - counting runs briefly after preset detected
// - internal interval source through prescaler
// - scan stops after preset acquisitions count
module msc_core #(
    parameter int unsigned SELFTEST_CYC = msc_pkg::SELFTEST_CYC
) (
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic bcast_latch,
    input wire logic [31:0] ch_in,
    input wire logic ref_pulse,
    input wire logic tb_pulse,
    input wire logic [3:0] ctrl_in,
    output logic [3:0] ctrl_out,
    output msc_pkg::msc_mem_t mem_o,
    input wire logic mem_ack,
    input wire logic [31:0] mem_rdata,
    output logic led_power,
    output logic led_ready,
    output logic led_run
);

    // ********************************************************
    // declarations
    // ********************************************************
    logic [msc_pkg::NSYNC-1:0] s1_r, s2_r, s3_r;
    logic [msc_pkg::CW-1:0] cnt_r [msc_pkg::NCH];
    logic [msc_pkg::CW-1:0] shd_r [msc_pkg::NCH];
    logic [msc_pkg::XW-1:0] xhi_r [2];
    logic [msc_pkg::XW-1:0] xsh_r [2];
    logic [msc_pkg::CW-1:0] pv_r [2];
    logic [7:0] ctrl_r;
    logic [31:0] acq_pre_r, acq_cnt_r, lne_pre_r, lne_div_r;
    logic [31:0] pen_r, hit_r, prdata_r, st_cnt_r;
    logic [msc_pkg::MAW-1:0] ptr_r;
    logic [4:0] w_r;
    logic [3:0] stop_r, ctrl_out_r;
    logic run_r, done_r, ovr_r, rdy_r;
    msc_pkg::msc_state_t st_r;
    msc_pkg::msc_mem_t mem_r;
    logic [31:0] rd_mux, hit_now, pk_word;
    logic map_ok;

    // ********************************************************
    // input synchronisers and edge detect
    // ********************************************************
    wire [msc_pkg::NSYNC-1:0] async_in = {ctrl_in, tb_pulse, ref_pulse,
        ch_in};

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            s1_r <= '0;
            s2_r <= '0;
            s3_r <= '0;
        end else begin
            s1_r <= async_in;
            s2_r <= s1_r;
            s3_r <= s2_r;
        end
    end

    wire [msc_pkg::NSYNC-1:0] rise = s2_r & ~s3_r;
    wire [3:0] ci_rise = rise[msc_pkg::I_CI +: 4];
    wire inhibit = s2_r[msc_pkg::I_CI + 1];

    // ********************************************************
    // mode decode
    // ********************************************************
    wire msc_pkg::msc_mode_t mode =
        msc_pkg::msc_mode_t'(ctrl_r[msc_pkg::C_MD +: 2]);
    wire [1:0] cmp_f = ctrl_r[msc_pkg::C_CMP +: 2];
    wire msc_pkg::msc_cmp_t cmp = (cmp_f == 2'h0) ? msc_pkg::CMP_32 :
        (cmp_f == 2'h1) ? msc_pkg::CMP_16 : msc_pkg::CMP_8;
    wire hist = ctrl_r[msc_pkg::C_HIST];
    wire is_scaler = mode == msc_pkg::MD_SCALER;
    wire is_preset = mode == msc_pkg::MD_PRESET;
    wire is_mcs = mode == msc_pkg::MD_MCS;

    // ********************************************************
    // apb decode
    // ********************************************************
    wire setup = psel & ~penable;
    wire wr_acc = psel & penable & pwrite & map_ok;
    wire we_ctrl = wr_acc & (paddr == msc_pkg::A_CTRL);
    wire we_apre = wr_acc & (paddr == msc_pkg::A_ACQ_PRE);
    wire we_lpre = wr_acc & (paddr == msc_pkg::A_LNE_PRE);
    wire we_pv1 = wr_acc & (paddr == msc_pkg::A_PV1);
    wire we_pv2 = wr_acc & (paddr == msc_pkg::A_PV2);
    wire we_pen = wr_acc & (paddr == msc_pkg::A_PEN);
    wire we_hit = wr_acc & (paddr == msc_pkg::A_HIT);
    wire we_key = wr_acc & (paddr == msc_pkg::A_KEY);
    wire k_latch = we_key & pwdata[msc_pkg::K_LATCH];
    wire k_clr = we_key & pwdata[msc_pkg::K_CLR];
    wire k_bin0 = we_key & pwdata[msc_pkg::K_BIN0];
    wire k_en = we_key & pwdata[msc_pkg::K_EN] & rdy_r;
    wire k_dis = we_key & pwdata[msc_pkg::K_DIS];
    wire in_cnt = paddr[11:7] == msc_pkg::A_CNT[11:7];
    wire in_shd = paddr[11:7] == msc_pkg::A_SHD[11:7];
    wire [4:0] ridx = paddr[6:2];
    wire [31:0] status = {20'h00000, rdy_r, ovr_r, done_r, run_r,
        ctrl_r};

    always_comb begin
        rd_mux = 32'h0000_0000;
        map_ok = paddr[1:0] == 2'h0;
        if (in_cnt)
            rd_mux = cnt_r[ridx];
        else if (in_shd)
            rd_mux = shd_r[ridx];
        else begin
            case (paddr)
                msc_pkg::A_CTRL: rd_mux = status;
                msc_pkg::A_ID: rd_mux = msc_pkg::MODULE_ID;
                msc_pkg::A_ACQ_PRE: rd_mux = acq_pre_r;
                msc_pkg::A_ACQ_CNT: rd_mux = acq_cnt_r;
                msc_pkg::A_LNE_PRE: rd_mux = lne_pre_r;
                msc_pkg::A_PV1: rd_mux = pv_r[0];
                msc_pkg::A_PV2: rd_mux = pv_r[1];
                msc_pkg::A_PEN: rd_mux = pen_r;
                msc_pkg::A_HIT: rd_mux = hit_r;
                msc_pkg::A_KEY: rd_mux = 32'h0000_0000;
                msc_pkg::A_PTR: rd_mux = {8'h00, ptr_r};
                msc_pkg::A_XHI1: rd_mux = {16'h0000, xsh_r[0]};
                msc_pkg::A_XHI17: rd_mux = {16'h0000, xsh_r[1]};
                default: map_ok = 1'b0;
            endcase
        end
    end

    assign pready = 1'b1;
    assign pslverr = psel & penable & ~map_ok;
    assign prdata = prdata_r;

    // ********************************************************
    // configuration registers
    // ********************************************************
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            ctrl_r <= msc_pkg::CTRL_RST;
            acq_pre_r <= 32'h0000_0000;
            lne_pre_r <= 32'h0000_0000;
            pv_r[0] <= 32'h0000_0000;
            pv_r[1] <= 32'h0000_0000;
            pen_r <= 32'h0000_0000;
            prdata_r <= 32'h0000_0000;
        end else begin
            if (setup)
                prdata_r <= rd_mux;
            if (we_ctrl)
                ctrl_r <= pwdata[7:0];
            if (we_apre)
                acq_pre_r <= pwdata;
            if (we_lpre)
                lne_pre_r <= pwdata;
            if (we_pv1)
                pv_r[0] <= pwdata;
            if (we_pv2)
                pv_r[1] <= pwdata;
            if (we_pen)
                pen_r <= pwdata;
        end
    end

    // ********************************************************
    // self test
    // ********************************************************
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            st_cnt_r <= 32'h0000_0000;
            rdy_r <= 1'b0;
        end else if (!rdy_r) begin
            st_cnt_r <= st_cnt_r + 32'h0000_0001;
            rdy_r <= st_cnt_r == 32'(SELFTEST_CYC - 1);
        end
    end

    assign led_power = 1'b1;
    assign led_ready = rdy_r;
    assign led_run = run_r;

    // ********************************************************
    // interval strobe source and prescaler
    // ********************************************************
    wire lne_src = ctrl_r[msc_pkg::C_LNEI] | ci_rise[0];
    wire next_interval_strobe = lne_src & (lne_div_r == lne_pre_r);

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n)
            lne_div_r <= 32'h0000_0000;
        else if (!run_r || next_interval_strobe)
            lne_div_r <= 32'h0000_0000;
        else if (lne_src)
            lne_div_r <= lne_div_r + 32'h0000_0001;
    end

    // ********************************************************
    // counters, latch and shadow set
    // ********************************************************
    wire cnt_en = run_r & ~inhibit;
    wire ch0_src = ctrl_r[msc_pkg::C_TB] ? rise[msc_pkg::I_TB] :
        ctrl_r[msc_pkg::C_REF] ? rise[msc_pkg::I_REF] : rise[0];
    wire [31:0] inc = cnt_en ? {rise[31:1], ch0_src} : 32'h0000_0000;
    wire clr = k_clr | ci_rise[2];
    wire mcs_snap = is_mcs & (st_r == msc_pkg::ST_RUN) &
        next_interval_strobe;
    wire latch_ev = (mode == msc_pkg::MD_LATCH) &
        (next_interval_strobe | k_latch | bcast_latch);
    wire snap = latch_ev | mcs_snap;

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            for (int i = 0; i < msc_pkg::NCH; i++) begin
                cnt_r[i] <= 32'h0000_0000;
                shd_r[i] <= 32'h0000_0000;
            end
        end else begin
            for (int i = 0; i < msc_pkg::NCH; i++) begin
                if (snap)
                    shd_r[i] <= cnt_r[i];
                if (clr)
                    cnt_r[i] <= 32'h0000_0000;
                else if (mcs_snap)
                    cnt_r[i] <= {31'h0000_0000, inc[i]};
                else if (inc[i])
                    cnt_r[i] <= cnt_r[i] + 32'h0000_0001;
            end
        end
    end

    // upper 16 bits for channels 1 and 17 in plain scaler mode
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            xhi_r[0] <= 16'h0000;
            xhi_r[1] <= 16'h0000;
            xsh_r[0] <= 16'h0000;
            xsh_r[1] <= 16'h0000;
        end else begin
            for (int k = 0; k < 2; k++) begin
                if (snap)
                    xsh_r[k] <= xhi_r[k];
                if (clr)
                    xhi_r[k] <= 16'h0000;
                else if (is_scaler && inc[k * 16] &&
                         cnt_r[k * 16] == 32'hFFFF_FFFF)
                    xhi_r[k] <= xhi_r[k] + 16'h0001;
            end
        end
    end

    // ********************************************************
    // preset compare and stop
    // ********************************************************
    always_comb begin
        for (int i = 0; i < msc_pkg::NCH; i++)
            hit_now[i] = pen_r[i] &
                (cnt_r[i] >= pv_r[i / 16]);
    end

    wire preset_trig = is_preset & run_r & (|hit_now);
    wire stop_fire = stop_r == 4'h1;

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n)
            stop_r <= 4'h0;
        else if (stop_r != 4'h0)
            stop_r <= stop_r - 4'h1;
        else if (preset_trig)
            stop_r <= 4'(msc_pkg::STOP_CYC);
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n)
            hit_r <= 32'h0000_0000;
        else
            hit_r <= (hit_r & ~(k_en ? 32'hFFFF_FFFF :
                we_hit ? pwdata : 32'h0000_0000)) |
                (preset_trig ? hit_now : 32'h0000_0000);
    end

    // ********************************************************
    // run control
    // ********************************************************
    wire [4:0] last_w = (cmp == msc_pkg::CMP_32) ? 5'h1F :
        (cmp == msc_pkg::CMP_16) ? 5'h0F : 5'h07;
    wire fin = (st_r == msc_pkg::ST_WR) & mem_ack & (w_r == last_w);
    wire [31:0] acq_nxt = acq_cnt_r + 32'h0000_0001;
    wire acq_end = fin & (acq_pre_r != 32'h0000_0000) &
        (acq_nxt == acq_pre_r);

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            run_r <= 1'b0;
            done_r <= 1'b0;
            ovr_r <= 1'b0;
        end else begin
            if (k_dis || stop_fire || acq_end)
                run_r <= 1'b0;
            else if (k_en)
                run_r <= 1'b1;
            if (acq_end)
                done_r <= 1'b1;
            else if (k_en)
                done_r <= 1'b0;
            if (is_mcs && next_interval_strobe &&
                (st_r == msc_pkg::ST_RD || st_r == msc_pkg::ST_WR))
                ovr_r <= 1'b1;
            else if (k_en)
                ovr_r <= 1'b0;
        end
    end

    // ********************************************************
    // scan word packing and histogram add
    // ********************************************************
    function automatic logic [31:0] lane_add(
        input logic [31:0] a,
        input logic [31:0] b,
        input msc_pkg::msc_cmp_t c
    );
        logic [31:0] r;
        r = a + b;
        if (c == msc_pkg::CMP_16)
            r = {a[31:16] + b[31:16], a[15:0] + b[15:0]};
        else if (c == msc_pkg::CMP_8)
            r = {a[31:24] + b[31:24], a[23:16] + b[23:16],
                 a[15:8] + b[15:8], a[7:0] + b[7:0]};
        return r;
    endfunction : lane_add

    wire [4:0] h0 = {w_r[3:0], 1'b0};
    wire [4:0] h1 = {w_r[3:0], 1'b1};
    wire [4:0] b0 = {w_r[2:0], 2'h0};
    wire [4:0] b1 = {w_r[2:0], 2'h1};
    wire [4:0] b2 = {w_r[2:0], 2'h2};
    wire [4:0] b3 = {w_r[2:0], 2'h3};
    assign pk_word = (cmp == msc_pkg::CMP_32) ? shd_r[w_r] :
        (cmp == msc_pkg::CMP_16) ?
        {shd_r[h1][15:0], shd_r[h0][15:0]} :
        {shd_r[b3][7:0], shd_r[b2][7:0],
         shd_r[b1][7:0], shd_r[b0][7:0]};
    wire [msc_pkg::MAW-1:0] w_addr = ptr_r + msc_pkg::MAW'(w_r);
    wire [msc_pkg::MAW-1:0] w_nxt = w_addr + msc_pkg::MAW'(1);
    wire bin0 = hist & (k_bin0 | ci_rise[3]);

    // ********************************************************
    // scan state machine and memory port
    // ********************************************************
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            st_r <= msc_pkg::ST_IDLE;
            mem_r <= '0;
            w_r <= 5'h00;
            ptr_r <= '0;
            acq_cnt_r <= 32'h0000_0000;
        end else begin
            if (k_en) begin
                acq_cnt_r <= 32'h0000_0000;
                if (!hist)
                    ptr_r <= '0;
            end
            if (bin0)
                ptr_r <= '0;
            unique case (st_r)
                msc_pkg::ST_IDLE: begin
                    if (run_r && is_mcs)
                        st_r <= msc_pkg::ST_RUN;
                end
                msc_pkg::ST_RUN: begin
                    if (!run_r) begin
                        st_r <= msc_pkg::ST_IDLE;
                    end else if (mcs_snap) begin
                        w_r <= 5'h00;
                        st_r <= hist ? msc_pkg::ST_RD : msc_pkg::ST_WR;
                    end
                end
                msc_pkg::ST_RD: begin
                    mem_r <= {1'b1, 1'b0, w_addr, 32'h0000_0000};
                    if (mem_r.req && mem_ack) begin
                        mem_r <= {1'b1, 1'b1, w_addr,
                            lane_add(mem_rdata, pk_word, cmp)};
                        st_r <= msc_pkg::ST_WR;
                    end
                end
                msc_pkg::ST_WR: begin
                    if (!mem_r.req)
                        mem_r <= {1'b1, 1'b1, w_addr, pk_word};
                    if (mem_r.req && mem_ack) begin
                        mem_r <= '0;
                        if (w_r == last_w) begin
                            ptr_r <= bin0 ? '0 : w_nxt;
                            acq_cnt_r <= acq_nxt;
                            st_r <= msc_pkg::ST_RUN;
                        end else begin
                            w_r <= w_r + 5'h01;
                            st_r <= hist ? msc_pkg::ST_RD :
                                msc_pkg::ST_WR;
                        end
                    end
                end
            endcase
        end
    end

    assign mem_o = mem_r;

    // ********************************************************
    // front panel outputs
    // ********************************************************
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n)
            ctrl_out_r <= 4'h0;
        else
            ctrl_out_r <= {done_r, |hit_r, next_interval_strobe,
                cnt_en};
    end

    assign ctrl_out = ctrl_out_r;

endmodule : msc_core

// ===== msc_core_properties.sv
/* Port checker for msc_core.
   Bound into every msc_core; single mclk domain. */
module msc_core_props (
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic [3:0] ctrl_out,
    input wire msc_pkg::msc_mem_t mem_o,
    input wire logic mem_ack,
    input wire logic led_power,
    input wire logic led_ready,
    input wire logic led_run
);
    // ********
    // properties
    // ********
    default clocking @(posedge mclk);
    endclocking
    default disable iff (!reset_n);
    wire logic wr_acc = psel && penable && pwrite;
    sequence rd_done;
        mem_o.req && !mem_o.we && mem_ack;
    endsequence
    sequence wr_next;
        mem_o.req && mem_o.we;
    endsequence
    power_led_a: assert property (led_power)
        else $error("power led off");
    run_ready_a: assert property (led_run |-> led_ready)
        else $error("running before self test end");
    id_read_a: assert property (psel && !penable &&
        paddr == msc_pkg::A_ID |=> prdata == msc_pkg::MODULE_ID)
        else $error("id word wrong");
    mem_hold_a: assert property (mem_o.req && !mem_ack |=>
        mem_o.req && $stable(mem_o.addr))
        else $error("memory request dropped early");
    hist_rmw_a: assert property (rd_done |=> wr_next ##0
        mem_o.addr == $past(mem_o.addr))
        else $error("histogram write missing");
    preset_stop_a: assert property ($rose(ctrl_out[2]) |->
        ##[0:2] !led_run)
        else $error("run after preset hit");
    hit_sticky_a: assert property ($fell(ctrl_out[2]) |->
        $past(wr_acc, 2))
        else $error("hit lost without write");
    done_stop_a: assert property ($rose(ctrl_out[3]) |-> !led_run)
        else $error("run after scan done");
endmodule : msc_core_props

bind msc_core msc_core_props u_props (.*);

// ===== msc_mem_model.sv
/* Behavioural word memory on the scan port.
   Acks each held request after 0..3 random idle cycles. */
module msc_mem_model (
    input wire logic mclk,
    input wire logic reset_n,
    input wire msc_pkg::msc_mem_t mem_o,
    output logic mem_ack,
    output logic [31:0] mem_rdata
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [31:0] mem [0:255];
    int wait_r;
    always @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            mem_ack <= 1'b0;
            mem_rdata <= 32'h0;
            wait_r <= 0;
        end else begin
            mem_ack <= 1'b0;
            // no stale read data outside the ack cycle
            mem_rdata <= ~mem_rdata;
            if (mem_o.req && !mem_ack) begin
                if (wait_r == 0) begin
                    mem_ack <= 1'b1;
                    wait_r <= $urandom_range(3);
                    if (mem_o.we)
                        mem[mem_o.addr[7:0]] <= mem_o.wdata;
                    else
                        mem_rdata <= mem[mem_o.addr[7:0]];
                end else
                    wait_r <= wait_r - 1;
            end
        end
    end
endmodule : msc_mem_model

// ===== tb.sv
/* Self-checking bench for msc_core.
   Assumes msc_mem_model as memory; 10 MHz mclk. */
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin \
    err_total++; $display("[FAIL] %s exp %h got %h", n, e, g); end end
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic mclk, reset_n, psel, penable, pwrite, bcast_latch, ref_pulse, tb_pulse;
    logic pready, pslverr, mem_ack, led_power, led_ready, led_run;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, ch_in, rv, stim_mask, m, mem_rdata;
    logic [3:0] ctrl_out, ctrl_in;
    logic [31:0] exp_cnt [32];
    logic [31:0] snap [32];
    msc_pkg::msc_mem_t mem_o;
    int err_total, num_checks;
    msc_core #(.SELFTEST_CYC(16)) uut (.*);
    msc_mem_model mem_model (.*);
    initial begin
        mclk = 1'b0;
        forever #50 mclk = ~mclk;
    end
    // random pulse trains, rises counted here
    always @(posedge mclk) begin
        m = $urandom & stim_mask;
        ch_in <= ch_in ^ m;
        for (int i = 0; i < 32; i++)
            if (m[i] && !ch_in[i]) exp_cnt[i] = exp_cnt[i] + 1;
    end
    task automatic apb(input logic w, input logic [11:0] a,
            input logic [31:0] d);
        int n = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        do begin
            @(posedge mclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n == 20) err_total++;
        rv = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge mclk);
    endtask : apb
    task automatic chk_rd(input logic [11:0] a, input logic [31:0] e,
            input string n);
        apb(1'b0, a, 32'h0);
        `CHK(n, e, rv)
    endtask : chk_rd
    task automatic end_of_test;
        $display("checks %0d errors %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : end_of_test
    initial begin
        #2_000_000;
        err_total++;
        end_of_test();
    end
    // ********
    // main sequence
    // ********
    initial begin
        void'($urandom(76));
        {reset_n, psel, penable, pwrite, bcast_latch} = 5'h00;
        {paddr, pwdata, ch_in, stim_mask, ctrl_in, ref_pulse, tb_pulse} = '0;
        {err_total, num_checks} = '0;
        exp_cnt = '{default: 32'h0};
        repeat (3) @(posedge mclk);
        reset_n <= 1'b1;
        repeat (18) @(posedge mclk);
        `CHK("ready", 1'b1, led_ready)
        chk_rd(msc_pkg::A_ID, msc_pkg::MODULE_ID, "id");
        apb(1'b1, msc_pkg::A_CTRL, 32'h0);
        apb(1'b1, msc_pkg::A_KEY, 32'h0000000A);
        stim_mask = 32'hFFFFFFFF;
        repeat (100) @(posedge mclk);
        stim_mask = 32'h0;
        repeat (6) @(posedge mclk);
        for (int i = 0; i < 32; i++)
            chk_rd(msc_pkg::A_CNT + 12'(4 * i), exp_cnt[i], "cnt");
        apb(1'b1, msc_pkg::A_CTRL, 32'h1);
        for (int s = 0; s < 2; s++) begin
            stim_mask = $urandom;
            repeat (50) @(posedge mclk);
            stim_mask = 32'h0;
            repeat (6) @(posedge mclk);
            snap = exp_cnt;
            if (s == 0) apb(1'b1, msc_pkg::A_KEY, 32'h1);
            else begin
                bcast_latch <= 1'b1;
                @(posedge mclk);
                bcast_latch <= 1'b0;
            end
            stim_mask = 32'hFFFFFFFF;
            repeat (50) @(posedge mclk);
            stim_mask = 32'h0;
            for (int i = 0; i < 32; i++)
                chk_rd(msc_pkg::A_SHD + 12'(4 * i), snap[i], "shd");
        end
        apb(1'b1, msc_pkg::A_KEY, 32'h10);
        apb(1'b1, msc_pkg::A_CTRL, 32'h2);
        apb(1'b1, msc_pkg::A_PV1, 32'h5);
        apb(1'b1, msc_pkg::A_PEN, 32'h8);
        apb(1'b1, msc_pkg::A_KEY, 32'h0000000A);
        stim_mask = 32'h8;
        for (int n = 0; n < 500 && led_run !== 1'b0; n++) @(posedge mclk);
        stim_mask = 32'h0;
        repeat (6) @(posedge mclk);
        `CHK("run", 1'b0, led_run)
        chk_rd(msc_pkg::A_HIT, 32'h8, "hit");
        chk_rd(msc_pkg::A_HIT, 32'h8, "hit kept");
        apb(1'b0, msc_pkg::A_CNT + 12'hC, 32'h0);
        `CHK("stop", 1'b1, rv >= 5 && rv <= 6)
        apb(1'b1, msc_pkg::A_HIT, 32'h8);
        chk_rd(msc_pkg::A_HIT, 32'h0, "hit clr");
        apb(1'b1, msc_pkg::A_KEY, 32'h10);
        apb(1'b1, msc_pkg::A_ACQ_PRE, 32'h3);
        apb(1'b1, msc_pkg::A_LNE_PRE, 32'd399);
        for (int p = 0; p < 4; p++) begin
            apb(1'b1, msc_pkg::A_CTRL, (p == 3) ? 32'h87 : 32'h83 | p << 3);
            if (p == 3) begin
                foreach (snap[i]) snap[i] = $urandom;
                foreach (snap[i]) mem_model.mem[i] = snap[i];
                apb(1'b1, msc_pkg::A_ACQ_PRE, 32'h1);
                apb(1'b1, msc_pkg::A_KEY, 32'h6);
            end
            apb(1'b1, msc_pkg::A_KEY, 32'h8);
            repeat (2) @(posedge mclk);
            for (int n = 0; n < 3000 && ctrl_out[3] !== 1'b1; n++)
                @(posedge mclk);
            if (p < 3) begin
                chk_rd(msc_pkg::A_ACQ_CNT, 32'h3, "acq");
                chk_rd(msc_pkg::A_PTR, 32'(3 * (32 >> p)), "ptr");
            end
        end
        for (int i = 0; i < 32; i++)
            `CHK("hist", snap[i], mem_model.mem[i])
        end_of_test();
    end
endmodule : tb
